// >>> hw/dsp_regs.v
// status, saved-flags, page and family-identity registers of the debug unit
`default_nettype none
`include "dsp_consts.vh"

module dsp_regs #(
  parameter [7:0] FAMILY_IDENTITY = 8'h5a  // arbitrary identity value
) (
  input  wire        clk_i,            // system clock
  input  wire        sys_rst_i,        // synchronous reset, active high
  input  wire        ssc_mode_i,       // special single chip mode
  input  wire        secured_i,        // device secured by flash byte
  input  wire        reg_wr_i,         // register write strobe from serial command unit
  input  wire        reg_rd_i,         // register read strobe from serial command unit
  input  wire        fw_wr_i,          // write comes from standard firmware
  input  wire        secure_fw_i,      // write comes from secure firmware
  input  wire [17:0] reg_addr_i,       // register global address
  input  wire [7:0]  reg_wdata_i,      // register write data
  input  wire        entry_req_i,      // request to enter debug mode
  input  wire        cmd_rx_i,         // a new debug command received
  input  wire        data_done_i,      // data phase of a command complete
  input  wire        step_cmd_i,       // single-step command recognized
  input  wire        resume_cmd_i,     // resume or resume-until command
  input  wire [7:0]  cond_flags_i,     // cpu condition flags
  output reg  [7:0]  reg_rdata_o,      // register read data
  output wire        debug_enable_o,   // debug enable bit
  output wire        debug_active_o,   // debug mode active, firmware table mapped
  output wire        secure_table_o,   // secure firmware table overlays standard
  output wire        sec_bits_wr_ok_o, // flash security bits may be changed
  output wire [7:0]  saved_flags_o,    // flags restored on return to user code
  output wire        page_access_enable_o, // paged debug access enable
  output wire [3:0]  page_select_o,    // program page for paged access
  output wire        global_access_o   // global access by register commands; tied low, never granted
);
  // state registers and their next values
  reg        enable_q;
  reg        enable_d;
  reg        active_q;
  reg        active_d;
  reg        shift_valid_q;
  reg        shift_valid_d;
  reg        step_q;
  reg        step_d;
  reg        unlock_q;
  reg        unlock_d;
  reg  [7:0] saved_q;
  reg  [7:0] saved_d;
  reg  [7:0] page_q;
  reg  [7:0] page_d;
  reg  [7:0] rdata_d;
  reg        rst_seen_q;

  // access qualifiers and decoded strobes
  wire       hit_status;
  wire       hit_saved;
  wire       hit_page;
  wire       hit_family;
  wire       locked;
  wire       acc_ok;
  wire       secure_path;
  wire       live;
  wire       wr_stat;
  wire       wr_saved;
  wire       wr_page;
  wire       wr_enable;
  wire       wr_unlk;
  wire       enter;
  wire       exit_now;
  wire [7:0] status_word;

  // true when the bus address names the given register
  function addr_hit;
    input [`DSP_ADDR_W-1:0] addr;
    input [`DSP_ADDR_W-1:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // status byte as the host sees it; unimplemented bits stay zero
  function [7:0] pack_status;
    input en;
    input act;
    input valid;
    input step;
    input unlk;
    begin
      pack_status                       = `DSP_ZERO8;
      pack_status[`DSP_BIT_ENABLE]      = en;
      pack_status[`DSP_BIT_ACTIVE]      = act;
      pack_status[`DSP_BIT_SHIFT_VALID] = valid;
      pack_status[`DSP_BIT_STEP]        = step;
      pack_status[`DSP_BIT_UNLOCK]      = unlk;
    end
  endfunction

  // debug comes up enabled and active only in special single chip while not secured
  function open_from_reset;
    input ssc;
    input sec;
    begin
      open_from_reset = ssc & ~sec;
    end
  endfunction

  assign hit_status  = addr_hit(reg_addr_i, `DSP_ADDR_STATUS);
  assign hit_saved   = addr_hit(reg_addr_i, `DSP_ADDR_SAVED);
  assign hit_page    = addr_hit(reg_addr_i, `DSP_ADDR_PAGE);
  assign hit_family  = addr_hit(reg_addr_i, `DSP_ADDR_FAMILY);
  assign locked      = secured_i & ~unlock_q;
  assign acc_ok      = ~locked;
  assign secure_path = secured_i & ssc_mode_i & secure_fw_i;
  assign live        = ~rst_seen_q;
  assign wr_stat     = reg_wr_i & acc_ok & hit_status;
  assign wr_saved    = reg_wr_i & acc_ok & hit_saved;
  assign wr_page     = reg_wr_i & acc_ok & hit_page;
  // secure firmware sets enable once its erase check ends, pass or fail
  assign wr_enable   = reg_wr_i & hit_status & (acc_ok | secure_path);
  // while secured nobody but the secure firmware reaches the unlocked bit
  assign wr_unlk     = reg_wr_i & hit_status & (secured_i ? secure_path : 1'b1);
  assign enter       = entry_req_i & enable_q & ~active_q;
  assign exit_now    = wr_stat & fw_wr_i & active_q & ~reg_wdata_i[`DSP_BIT_ACTIVE];
  assign status_word = pack_status(enable_q, active_q, shift_valid_q, step_q, unlock_q);

  // enable: caught from the mode just after reset, then written
  always @* begin
    enable_d = enable_q;
    if (rst_seen_q)
      enable_d = open_from_reset(ssc_mode_i, secured_i);
    else if (wr_enable)
      enable_d = reg_wdata_i[`DSP_BIT_ENABLE];
  end

  // active: set on entry, cleared only by the firmware exit store
  always @* begin
    active_d = active_q;
    if (rst_seen_q)
      active_d = open_from_reset(ssc_mode_i, secured_i);
    else if (enter)
      active_d = 1'b1;
    else if (exit_now)
      active_d = 1'b0;
  end

  // a finished data phase wins over a clear in the same cycle
  always @* begin
    shift_valid_d = shift_valid_q;
    if (live & data_done_i)
      shift_valid_d = 1'b1;
    else if (live & (cmd_rx_i | exit_now))
      shift_valid_d = 1'b0;
  end

  // single-step flag; a new step wins over a resume
  always @* begin
    step_d = step_q;
    if (live & step_cmd_i)
      step_d = 1'b1;
    else if (live & resume_cmd_i)
      step_d = 1'b0;
  end

  always @* begin
    unlock_d = unlock_q;
    if (live & wr_unlk)
      unlock_d = reg_wdata_i[`DSP_BIT_UNLOCK];
  end

  // saved flags: mode value after reset, cpu flags on entry, else host data
  always @* begin
    saved_d = saved_q;
    if (rst_seen_q)
      saved_d = ssc_mode_i ? `DSP_SAVED_RST_SSC : `DSP_SAVED_RST;
    else if (enter)
      saved_d = cond_flags_i;
    else if (wr_saved)
      saved_d = reg_wdata_i;
  end

  always @* begin
    page_d = page_q;
    if (live & wr_page)
      page_d = reg_wdata_i & `DSP_PAGE_SEL_MASK;
  end

  // read path; only serial register commands reach here
  always @* begin
    rdata_d = reg_rdata_o;
    if (reg_rd_i) begin
      rdata_d = `DSP_ZERO8;
      if (acc_ok) begin
        if (hit_status)
          rdata_d = status_word;
        else if (hit_saved)
          rdata_d = saved_q;
        else if (hit_page)
          rdata_d = page_q;
        else if (hit_family & active_q)
          rdata_d = FAMILY_IDENTITY;
      end
    end
  end

  // one register per process, all on the synchronous reset
  always @(posedge clk_i) begin
    if (sys_rst_i)
      enable_q <= 1'b0;
    else
      enable_q <= enable_d;
  end

  always @(posedge clk_i) begin
    if (sys_rst_i)
      active_q <= 1'b0;
    else
      active_q <= active_d;
  end

  always @(posedge clk_i) begin
    if (sys_rst_i)
      shift_valid_q <= 1'b0;
    else
      shift_valid_q <= shift_valid_d;
  end

  always @(posedge clk_i) begin
    if (sys_rst_i)
      step_q <= 1'b0;
    else
      step_q <= step_d;
  end

  always @(posedge clk_i) begin
    if (sys_rst_i)
      unlock_q <= 1'b0;
    else
      unlock_q <= unlock_d;
  end

  always @(posedge clk_i) begin
    if (sys_rst_i)
      saved_q <= `DSP_SAVED_RST;
    else
      saved_q <= saved_d;
  end

  always @(posedge clk_i) begin
    if (sys_rst_i)
      page_q <= `DSP_PAGE_RST;
    else
      page_q <= page_d;
  end

  // marks the first edge after release, where mode-dependent values load
  always @(posedge clk_i) begin
    if (sys_rst_i)
      rst_seen_q <= 1'b1;
    else
      rst_seen_q <= 1'b0;
  end

  // read data holds until the next read strobe
  always @(posedge clk_i) begin
    if (sys_rst_i)
      reg_rdata_o <= `DSP_ZERO8;
    else
      reg_rdata_o <= rdata_d;
  end

  assign debug_enable_o       = enable_q;
  assign debug_active_o       = active_q;
  assign secure_table_o       = locked;
  assign sec_bits_wr_ok_o     = unlock_q & secured_i;
  assign saved_flags_o        = saved_q;
  assign page_access_enable_o = page_q[`DSP_BIT_PAE];
  assign page_select_o        = page_q[`DSP_PAGE_SEL_HI:`DSP_PAGE_SEL_LO];
  assign global_access_o      = 1'b0;
endmodule
`default_nettype wire

// >>> include/dsp_consts.vh
// constants for the debug status and page register block
`ifndef DSP_CONSTS_VH
`define DSP_CONSTS_VH
`define DSP_ADDR_W         18
`define DSP_ADDR_STATUS    18'h3_ff01
`define DSP_ADDR_SAVED     18'h3_ff06
`define DSP_ADDR_PAGE      18'h3_ff08
`define DSP_ADDR_FAMILY    18'h3_ff0f
`define DSP_BIT_ENABLE     7
`define DSP_BIT_ACTIVE     6
`define DSP_BIT_SHIFT_VALID 4
`define DSP_BIT_STEP       3
`define DSP_BIT_UNLOCK     1
`define DSP_BIT_PAE        7
`define DSP_SAVED_RST_SSC  8'hd8
`define DSP_SAVED_RST      8'h00
`define DSP_PAGE_RST       8'h00
`define DSP_PAGE_SEL_MASK  8'h8f
`define DSP_PAGE_SEL_HI    3
`define DSP_PAGE_SEL_LO    0
`define DSP_ZERO8          8'h00
`endif

// >>> tb/dsp_chk_checker.sv
// assertions on the debug status and page register block
`default_nettype none
module dsp_chk (
  input wire logic        clk_i,                // system clock
  input wire logic        sys_rst_i,            // synchronous reset
  input wire logic        reg_wr_i,             // write strobe
  input wire logic        reg_rd_i,             // read strobe
  input wire logic        fw_wr_i,              // standard firmware store
  input wire logic        entry_req_i,          // debug entry request
  input wire logic        debug_enable_o,       // debug enable bit
  input wire logic        debug_active_o,       // debug active bit
  input wire logic        secure_table_o,       // locked indication
  input wire logic        page_access_enable_o, // paging enable
  input wire logic        global_access_o,      // global access
  input wire logic [3:0]  page_select_o,        // program page
  input wire logic [17:0] reg_addr_i,           // register address
  input wire logic [7:0]  reg_wdata_i,          // write data
  input wire logic [7:0]  cond_flags_i,         // cpu flags
  input wire logic [7:0]  reg_rdata_o,          // read data
  input wire logic [7:0]  saved_flags_o         // saved flags
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire logic go = entry_req_i && debug_enable_o && !debug_active_o;
  wire logic wok = reg_wr_i && !secure_table_o;
  chk_no_global: assert property (!global_access_o) else $error("global");
  chk_entry_sets: assert property (go |=> debug_active_o) else $error("entry");
  chk_off_idle: assert property (!$past(sys_rst_i) && !debug_enable_o && !debug_active_o
    |=> !debug_active_o) else $error("idle");
  chk_act_stays: assert property (debug_active_o
    && !(wok && fw_wr_i && reg_addr_i == 18'h3_ff01 && !reg_wdata_i[6])
    |=> debug_active_o) else $error("exit");
  chk_flags_saved: assert property (go |=> saved_flags_o == $past(cond_flags_i))
    else $error("flags");
  chk_locked_read: assert property (reg_rd_i && secure_table_o
    |=> reg_rdata_o == 8'h00) else $error("locked");
  chk_page_write: assert property (wok && reg_addr_i == 18'h3_ff08
    |=> {page_access_enable_o, 3'h0, page_select_o} == ($past(reg_wdata_i) & 8'h8f))
    else $error("page");
  chk_family_gate: assert property (reg_rd_i && reg_addr_i == 18'h3_ff0f && !debug_active_o
    |=> reg_rdata_o == 8'h00) else $error("family");
  cover property (go);
  cover property (reg_rd_i && secure_table_o);
  cover property (wok && fw_wr_i);
endmodule
bind dsp_regs dsp_chk dsp_chk_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .fw_wr_i(fw_wr_i), .entry_req_i(entry_req_i), .cond_flags_i(cond_flags_i),
  .debug_enable_o(debug_enable_o), .debug_active_o(debug_active_o), .reg_addr_i(reg_addr_i),
  .secure_table_o(secure_table_o), .page_access_enable_o(page_access_enable_o),
  .global_access_o(global_access_o), .page_select_o(page_select_o), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .saved_flags_o(saved_flags_o));
`default_nettype wire

// >>> tb/dsp_host.sv
// debug host model issuing single register accesses
`default_nettype none
module dsp_host (
  input  wire logic        clk_i,       // system clock
  input  wire logic [7:0]  reg_rdata_o, // read answer
  output var  logic        reg_wr_i,    // write strobe
  output var  logic        reg_rd_i,    // read strobe
  output var  logic        fw_wr_i,     // standard firmware store
  output var  logic        secure_fw_i, // secure firmware store
  output var  logic [17:0] reg_addr_i,  // register address
  output var  logic [7:0]  reg_wdata_i  // write data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {reg_wr_i, reg_rd_i, fw_wr_i, secure_fw_i, reg_addr_i, reg_wdata_i} = '0;
  // one strobe per access, bus inverted once released
  task acc(input logic w, f, s, input logic [17:0] a, input logic [7:0] v, output logic [7:0] q);
    @(negedge clk_i);
    {reg_wr_i, reg_rd_i, fw_wr_i, secure_fw_i, reg_addr_i, reg_wdata_i} = {w, !w, f, s, a, v};
    @(negedge clk_i);
    q = reg_rdata_o;
    {reg_wr_i, reg_rd_i, fw_wr_i, secure_fw_i, reg_addr_i, reg_wdata_i} = {4'h0, ~a, ~v};
  endtask
endmodule
`default_nettype wire

// >>> tb/dsp_regs_test.sv
// self-checking bench for the debug status and page register block
`default_nettype none
module dsp_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, sys_rst_i = 1, ssc = 1, sec = 0;
  logic [4:0] ev = '0;
  logic [7:0] fl = 8'h00, d;
  wire logic wr, rd, fw, sfw, en, act, tbl, ok, pae, glb;
  wire logic [17:0] a;
  wire logic [7:0] wd, q, sv;
  wire logic [3:0] pg;
  int n_errors = 0, num_checks = 0, cyc = 0;
  initial forever #10 clk_i = ~clk_i;
  dsp_host dsp_host_inst (.clk_i(clk_i), .reg_rdata_o(q), .reg_wr_i(wr), .reg_rd_i(rd),
    .fw_wr_i(fw), .secure_fw_i(sfw), .reg_addr_i(a), .reg_wdata_i(wd));
  dsp_regs #(.FAMILY_IDENTITY(8'h3c)) dsp_regs_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .ssc_mode_i(ssc), .secured_i(sec), .reg_wr_i(wr), .reg_rd_i(rd), .fw_wr_i(fw),
    .secure_fw_i(sfw), .reg_addr_i(a), .reg_wdata_i(wd), .entry_req_i(ev[4]), .cmd_rx_i(ev[3]),
    .data_done_i(ev[2]), .step_cmd_i(ev[1]), .resume_cmd_i(ev[0]), .cond_flags_i(fl),
    .reg_rdata_o(q), .debug_enable_o(en), .debug_active_o(act), .secure_table_o(tbl),
    .sec_bits_wr_ok_o(ok), .saved_flags_o(sv), .page_access_enable_o(pae),
    .page_select_o(pg), .global_access_o(glb));
  task pc(input string n, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task w(input logic f, s, input logic [17:0] ad, input logic [7:0] v);
    dsp_host_inst.acc(1, f, s, ad, v, d);
  endtask
  // status unlocked bit is masked: its value when unsecured is left open
  task r(input logic [17:0] ad, input logic [7:0] e);
    dsp_host_inst.acc(0, 0, 0, ad, 8'h00, d);
    pc($sformatf("reg %h", ad), e, ad == 18'h3_ff01 ? d & 8'hfd : d);
  endtask
  task pulse(input logic [4:0] v);
    @(negedge clk_i) ev = v;
    @(negedge clk_i) ev = '0;
  endtask
  task rst(input logic m, s);
    {ssc, sec, sys_rst_i} = {m, s, 1'b1};
    repeat (4) @(negedge clk_i);
    sys_rst_i = 0;
    repeat (2) @(negedge clk_i);
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_i) if (++cyc == 3000) begin
    n_errors++;
    give_verdict;
  end
  initial begin
    rst(1, 0);
    r(18'h3_ff01, 8'hc0);
    r(18'h3_ff06, 8'hd8);
    r(18'h3_ff0f, 8'h3c);
    r(18'h3_ff02, 8'h00);
    w(0, 0, 18'h3_ff08, 8'hff); pc("page", 8'h8f, {pae, 3'h0, pg});
    r(18'h3_ff08, 8'h8f);
    w(0, 0, 18'h3_ff06, 8'h5a); pc("saved", 8'h5a, sv);
    r(18'h3_ff06, 8'h5a);
    pulse(5'h04); r(18'h3_ff01, 8'hd0);
    pulse(5'h08); r(18'h3_ff01, 8'hc0);
    pulse(5'h02); r(18'h3_ff01, 8'hc8);
    pulse(5'h01); r(18'h3_ff01, 8'hc0);
    pulse(5'h04); w(1, 0, 18'h3_ff01, 8'h80); r(18'h3_ff01, 8'h80);
    pc("active", 8'h00, {7'h00, act});
    r(18'h3_ff0f, 8'h00);
    fl = 8'h25; pulse(5'h10); r(18'h3_ff06, 8'h25);
    pc("active", 8'h01, {7'h00, act});
    r(18'h3_ff01, 8'hc0);
    w(0, 0, 18'h3_ff01, 8'h00); r(18'h3_ff01, 8'h40);
    w(1, 0, 18'h3_ff01, 8'h00); pulse(5'h10); r(18'h3_ff01, 8'h00);
    pc("global", 8'h00, {7'h00, glb});
    rst(1, 1); pc("enable", 8'h00, {7'h00, en});
    pc("table", 8'h01, {7'h00, tbl});
    r(18'h3_ff06, 8'h00);
    w(0, 1, 18'h3_ff01, 8'h80); pc("enable", 8'h01, {7'h00, en});
    pc("unlock", 8'h00, {7'h00, ok});
    w(0, 1, 18'h3_ff01, 8'h82); pc("unlock", 8'h01, {7'h00, ok});
    pc("table", 8'h00, {7'h00, tbl});
    w(0, 0, 18'h3_ff01, 8'h00); pc("unlock", 8'h01, {7'h00, ok});
    r(18'h3_ff06, 8'hd8);
    rst(0, 0); r(18'h3_ff06, 8'h00);
    r(18'h3_ff01, 8'h00);
    rst(0, 1); w(0, 1, 18'h3_ff01, 8'h02); pc("unlock", 8'h00, {7'h00, ok});
    r(18'h3_ff01, 8'h00);
    give_verdict;
  end
endmodule
`default_nettype wire
